// *** plo_dev.sv ***
// Potentiometer device: two-wire slave, logic outputs and shutdown control.
//
// Operation
// - Both logic outputs low from reset.
// - Logic output levels come from instruction byte.
// - Instruction-only write updates outputs, keeps wiper unless the center bit is set.
// - Accept instruction-only update after stopped write.
// - Accept instruction-only update after repeated start.
// - Shutdown by pin or soft power-down bit.
// - Soft shutdown keeps wiper, restores on command.
// - Commands still stored while shut down.
// - Looped output A releases shutdown when high.
// - Instruction bits: chan, center, spd, B, A.
// - Power-down pin is active low.
// - Shutdown opens A terminal, wiper to B.
// - Address 01011 plus two strap bits.
`timescale 1ns/1ps
module plo_dev
	import plo_pkg::*;
#(
	parameter int CHANNELS = 2
) (
	plo_if.dev link,
	input wire logic mclk,
	input wire logic resetn,
	input wire logic addr_strap_lo,
	input wire logic addr_strap_hi,
	input wire logic power_down_pin_n,
	output logic logic_out_a,
	output logic logic_out_b,
	output logic [CHANNELS-1:0] term_a_open,
	output logic [CHANNELS-1:0][7:0] wiper_position_register
);

	if (CHANNELS < 1 || CHANNELS > 2) begin : g_bad_channels
		$error("CHANNELS must be 1 or 2");
	end

	function automatic int chan_of(input logic [7:0] b);
		return (CHANNELS > 1) ? int'(b[PLO_B_CHAN]) : 0;
	endfunction : chan_of

	// ****************************************
	// Start and stop detection on the data wire
	// ****************************************
	// These flops toggle on data edges while the clock is high. Each toggle
	// settles at least half a bit before the next clock rise, where it is compared.
	logic start_tog_q, start_tog_d, stop_tog_q, stop_tog_d;

	always_comb begin
		start_tog_d = link.scl ? ~start_tog_q : start_tog_q;
		stop_tog_d = link.scl ? ~stop_tog_q : stop_tog_q;
	end

	always_ff @(negedge link.sda or negedge resetn) begin
		if (!resetn) begin
			start_tog_q <= 1'b0;
		end else begin
			start_tog_q <= start_tog_d;
		end
	end

	always_ff @(posedge link.sda or negedge resetn) begin
		if (!resetn) begin
			stop_tog_q <= 1'b0;
		end else begin
			stop_tog_q <= stop_tog_d;
		end
	end

	// ****************************************
	// Link-side frame decoder
	// ****************************************
	// The link clock stands still between frames, so this domain is reset
	// without its clock; resetn must be released while the link is idle.
	plo_dev_st_t st_q, st_d;
	logic [2:0] cnt_q, cnt_d;
	logic [6:0] sh_q, sh_d;
	logic rw_q, rw_d;
	logic [7:0] instr_q, instr_d;
	logic [7:0] data_q, data_d;
	logic itog_q, itog_d, dtog_q, dtog_d;
	logic start_seen_q, stop_seen_q;
	logic [1:0] strap_s1_q, strap_q;
	logic [7:0] shadow_q [CHANNELS];
	logic [7:0] shadow_d [CHANNELS];
	logic [7:0] byte_now;
	logic [7:0] rd_byte;
	logic oe_q, oe_d;

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		rw_d = rw_q;
		instr_d = instr_q;
		data_d = data_q;
		itog_d = itog_q;
		dtog_d = dtog_q;
		shadow_d = shadow_q;
		byte_now = {sh_q, link.sda};
		if (start_tog_q != start_seen_q) begin
			// A start, fresh or repeated, restarts decoding.
			st_d = PLO_D_ADDR;
			cnt_d = 3'h1;
			sh_d = {6'h00, link.sda};
		end else if (stop_tog_q != stop_seen_q) begin
			st_d = PLO_D_IDLE;
		end else begin
			case (st_q)
				PLO_D_ADDR: begin
					sh_d = byte_now[6:0];
					cnt_d = cnt_q + 3'h1;
					if (cnt_q == 3'h7) begin
						if (byte_now[7:1] == {PLO_ADDR_HI, strap_q}) begin
							st_d = PLO_D_ACK_A;
							rw_d = link.sda;
						end else begin
							st_d = PLO_D_IDLE;
						end
					end
				end
				PLO_D_ACK_A: begin
					cnt_d = 3'h0;
					st_d = rw_q ? PLO_D_RD : PLO_D_INSTR;
				end
				PLO_D_INSTR: begin
					sh_d = byte_now[6:0];
					cnt_d = cnt_q + 3'h1;
					if (cnt_q == 3'h7) begin
						// Fields are taken as the byte is acknowledged.
						instr_d = byte_now;
						itog_d = ~itog_q;
						st_d = PLO_D_ACK_I;
						if (byte_now[PLO_B_CENTER]) begin
							shadow_d[chan_of(byte_now)] = PLO_WIPER_RST;
						end
					end
				end
				PLO_D_ACK_I: begin
					cnt_d = 3'h0;
					st_d = PLO_D_DATA;
				end
				PLO_D_DATA: begin
					sh_d = byte_now[6:0];
					cnt_d = cnt_q + 3'h1;
					if (cnt_q == 3'h7) begin
						data_d = byte_now;
						dtog_d = ~dtog_q;
						shadow_d[chan_of(instr_q)] = byte_now;
						st_d = PLO_D_ACK_D;
					end
				end
				PLO_D_ACK_D: begin
					cnt_d = 3'h0;
					st_d = PLO_D_DATA;
				end
				PLO_D_RD: begin
					cnt_d = cnt_q + 3'h1;
					if (cnt_q == 3'h7) begin
						st_d = PLO_D_RACK;
					end
				end
				PLO_D_RACK: begin
					cnt_d = 3'h0;
					st_d = link.sda ? PLO_D_IDLE : PLO_D_RD;
				end
				default: begin
					st_d = PLO_D_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge link.scl or negedge resetn) begin
		if (!resetn) begin
			st_q <= PLO_D_IDLE;
			cnt_q <= 3'h0;
			sh_q <= 7'h00;
			rw_q <= 1'b0;
			instr_q <= 8'h00;
			data_q <= 8'h00;
			itog_q <= 1'b0;
			dtog_q <= 1'b0;
			start_seen_q <= 1'b0;
			stop_seen_q <= 1'b0;
			strap_s1_q <= 2'h0;
			strap_q <= 2'h0;
			for (int c = 0; c < CHANNELS; c++) begin
				shadow_q[c] <= PLO_WIPER_RST;
			end
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			rw_q <= rw_d;
			instr_q <= instr_d;
			data_q <= data_d;
			itog_q <= itog_d;
			dtog_q <= dtog_d;
			start_seen_q <= start_tog_q;
			stop_seen_q <= stop_tog_q;
			strap_s1_q <= {addr_strap_hi, addr_strap_lo};
			strap_q <= strap_s1_q;
			shadow_q <= shadow_d;
		end
	end

	// ****************************************
	// Data wire driver
	// ****************************************
	// Driven on the falling clock so changes fall in the low phase.
	always_comb begin
		rd_byte = shadow_q[chan_of(instr_q)];
		case (st_q)
			PLO_D_ACK_A, PLO_D_ACK_I, PLO_D_ACK_D: oe_d = 1'b1;
			PLO_D_RD: oe_d = ~rd_byte[~cnt_q];
			default: oe_d = 1'b0;
		endcase
	end

	always_ff @(negedge link.scl or negedge resetn) begin
		if (!resetn) begin
			oe_q <= 1'b0;
		end else begin
			oe_q <= oe_d;
		end
	end

	assign link.dev_sda_oe = oe_q;

	// ****************************************
	// Core-side state on the system clock
	// ****************************************
	logic [2:0] isync_q, dsync_q;
	logic [1:0] pin_sync_q;
	logic out_a_q, out_a_d, out_b_q, out_b_d;
	logic [CHANNELS-1:0] sd_q, sd_d, term_q, term_d;
	logic [7:0] wiper_q [CHANNELS];
	logic [7:0] wiper_d [CHANNELS];
	logic [CHANNELS-1:0][7:0] wout_q, wout_d;

	always_comb begin
		out_a_d = out_a_q;
		out_b_d = out_b_q;
		sd_d = sd_q;
		wiper_d = wiper_q;
		if (isync_q[2] ^ isync_q[1]) begin
			// No data byte is needed; only the center bit touches the wiper here.
			out_a_d = instr_q[PLO_B_OUTA];
			out_b_d = instr_q[PLO_B_OUTB];
			// A new instruction without the soft bit restores the wiper.
			sd_d[chan_of(instr_q)] = instr_q[PLO_B_SPD];
			if (instr_q[PLO_B_CENTER]) begin
				wiper_d[chan_of(instr_q)] = PLO_WIPER_RST;
			end
		end
		if (dsync_q[2] ^ dsync_q[1]) begin
			// Stored even while shut down.
			wiper_d[chan_of(instr_q)] = data_q;
		end
		for (int c = 0; c < CHANNELS; c++) begin
			term_d[c] = ~pin_sync_q[1] | sd_q[c];
			wout_d[c] = term_d[c] ? PLO_WIPER_AT_B : wiper_q[c];
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			isync_q <= 3'h0;
			dsync_q <= 3'h0;
			pin_sync_q <= 2'h3;
			out_a_q <= PLO_OUT_RST;
			out_b_q <= PLO_OUT_RST;
			sd_q <= '0;
			term_q <= '0;
			wout_q <= {CHANNELS{PLO_WIPER_RST}};
			for (int c = 0; c < CHANNELS; c++) begin
				wiper_q[c] <= PLO_WIPER_RST;
			end
		end else begin
			isync_q <= {isync_q[1:0], itog_q};
			dsync_q <= {dsync_q[1:0], dtog_q};
			pin_sync_q <= {pin_sync_q[0], power_down_pin_n};
			out_a_q <= out_a_d;
			out_b_q <= out_b_d;
			sd_q <= sd_d;
			term_q <= term_d;
			wout_q <= wout_d;
			wiper_q <= wiper_d;
		end
	end

	assign logic_out_a = out_a_q;
	assign logic_out_b = out_b_q;
	assign term_a_open = term_q;
	assign wiper_position_register = wout_q;

endmodule : plo_dev

// *** plo_pkg.sv ***
// Shared constants and state types for the potentiometer control link.
package plo_pkg;

	// ****************************************
	// Addressing and instruction layout
	// ****************************************
	localparam logic [4:0] PLO_ADDR_HI = 5'h0B;
	localparam int PLO_B_CHAN = 7;
	localparam int PLO_B_CENTER = 6;
	localparam int PLO_B_SPD = 5;
	localparam int PLO_B_OUTB = 4;
	localparam int PLO_B_OUTA = 3;

	// ****************************************
	// Reset and shutdown values
	// ****************************************
	localparam logic [7:0] PLO_WIPER_RST = 8'h80;
	localparam logic [7:0] PLO_WIPER_AT_B = 8'h00;
	localparam logic PLO_OUT_RST = 1'b0;

	// ****************************************
	// Timing and framing counts
	// ****************************************
	localparam int PLO_QDIV = 4;
	localparam logic [4:0] PLO_LAST_LONG = 5'h1A;
	localparam logic [4:0] PLO_LAST_SHORT = 5'h11;

	// ****************************************
	// State types
	// ****************************************
	typedef enum logic [3:0] {
		PLO_D_IDLE, PLO_D_ADDR, PLO_D_ACK_A, PLO_D_INSTR, PLO_D_ACK_I,
		PLO_D_DATA, PLO_D_ACK_D, PLO_D_RD, PLO_D_RACK
	} plo_dev_st_t;

	typedef enum logic [1:0] {
		PLO_H_IDLE, PLO_H_START, PLO_H_BIT, PLO_H_STOP
	} plo_host_st_t;

endpackage : plo_pkg

// *** plo_if.sv ***
// Two-wire link between the bus master and the potentiometer device.
`timescale 1ns/1ps
interface plo_if;
	logic scl;
	logic host_sda_oe;
	logic dev_sda_oe;
	logic sda;

	// The data wire is open drain with a pull-up.
	assign sda = ~(host_sda_oe | dev_sda_oe);

	modport host (output scl, output host_sda_oe, input sda);
	modport dev (input scl, input sda, output dev_sda_oe);
endinterface : plo_if

// *** plo_host.sv ***
// Bus master end: sends address, instruction and data frames to the device.
`timescale 1ns/1ps
module plo_host
	import plo_pkg::*;
#(
	parameter int QDIV = PLO_QDIV
) (
	plo_if.host link,
	input wire logic mclk,
	input wire logic resetn,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_read,
	input wire logic cmd_has_data,
	input wire logic cmd_hold,
	input wire logic [1:0] cmd_strap,
	input wire logic [7:0] cmd_instr,
	input wire logic [7:0] cmd_data,
	output logic done,
	output logic nack_seen,
	output logic [7:0] rd_data
);

	if (QDIV < 3 || QDIV > 255) begin : g_bad_qdiv
		$error("QDIV must be 3 to 255");
	end

	localparam logic [7:0] QLAST = 8'(QDIV - 1);

	// ****************************************
	// Frame sequencer
	// ****************************************
	// Each bit spends four quarters: low, high, high, low. Own data changes
	// only in the low phase; the wire is sampled at the end of the second
	// high quarter, after the two-flop synchroniser.
	plo_host_st_t st_q, st_d;
	logic [7:0] div_q, div_d;
	logic [1:0] qc_q, qc_d;
	logic [4:0] bit_q, bit_d, last_q, last_d;
	logic [26:0] tx_q, tx_d, rx_q, rx_d;
	logic hold_q, hold_d, read_q, read_d, hasd_q, hasd_d;
	logic scl_q, scl_d, oe_q, oe_d;
	logic ready_q, ready_d, done_q, done_d, nack_q, nack_d;
	logic [7:0] rdd_q, rdd_d;
	logic [1:0] sda_sync_q;
	logic qtick, finish;

	always_comb begin
		st_d = st_q;
		div_d = div_q;
		qc_d = qc_q;
		bit_d = bit_q;
		last_d = last_q;
		tx_d = tx_q;
		rx_d = rx_q;
		hold_d = hold_q;
		read_d = read_q;
		hasd_d = hasd_q;
		scl_d = scl_q;
		oe_d = oe_q;
		ready_d = ready_q;
		done_d = 1'b0;
		nack_d = nack_q;
		rdd_d = rdd_q;
		finish = 1'b0;
		qtick = (div_q == QLAST);
		if (st_q != PLO_H_IDLE) begin
			div_d = qtick ? 8'h00 : div_q + 8'h01;
			if (qtick) begin
				qc_d = qc_q + 2'h1;
			end
		end
		case (st_q)
			PLO_H_IDLE: begin
				if (cmd_valid && ready_q) begin
					ready_d = 1'b0;
					st_d = PLO_H_START;
					div_d = 8'h00;
					qc_d = 2'h0;
					bit_d = 5'h00;
					rx_d = 27'h0;
					hold_d = cmd_hold;
					read_d = cmd_read;
					hasd_d = cmd_has_data & ~cmd_read;
					last_d = (cmd_has_data && !cmd_read) ? PLO_LAST_LONG
						: PLO_LAST_SHORT;
					if (cmd_read) begin
						tx_d = {PLO_ADDR_HI, cmd_strap, 2'h3, 8'hFF, 1'b1,
							9'h1FF};
					end else if (cmd_has_data) begin
						tx_d = {PLO_ADDR_HI, cmd_strap, 2'h1, cmd_instr, 1'b1,
							cmd_data, 1'b1};
					end else begin
						// Instruction only: outputs change, wiper stays unless the center bit is set.
						tx_d = {PLO_ADDR_HI, cmd_strap, 2'h1, cmd_instr, 1'b1,
							9'h1FF};
					end
				end
			end
			PLO_H_START: begin
				// Works from idle and from a held bus alike.
				if (qtick) begin
					case (qc_q)
						2'h0: scl_d = 1'b1;
						2'h1: oe_d = 1'b1;
						2'h2: scl_d = 1'b0;
						default: begin
							oe_d = ~tx_q[26];
							st_d = PLO_H_BIT;
						end
					endcase
				end
			end
			PLO_H_BIT: begin
				if (qtick) begin
					case (qc_q)
						2'h0: scl_d = 1'b1;
						2'h1: scl_d = 1'b1;
						2'h2: begin
							rx_d = {rx_q[25:0], sda_sync_q[1]};
							scl_d = 1'b0;
						end
						default: begin
							tx_d = {tx_q[25:0], 1'b1};
							bit_d = bit_q + 5'h01;
							if (bit_q == last_q) begin
								if (hold_q) begin
									oe_d = 1'b0;
									finish = 1'b1;
								end else begin
									oe_d = 1'b1;
									st_d = PLO_H_STOP;
								end
							end else begin
								oe_d = ~tx_q[25];
							end
						end
					endcase
				end
			end
			PLO_H_STOP: begin
				if (qtick) begin
					case (qc_q)
						2'h0: scl_d = 1'b1;
						2'h1: oe_d = 1'b0;
						2'h2: scl_d = 1'b1;
						default: finish = 1'b1;
					endcase
				end
			end
			default: begin
				st_d = PLO_H_IDLE;
			end
		endcase
		if (finish) begin
			st_d = PLO_H_IDLE;
			ready_d = 1'b1;
			done_d = 1'b1;
			if (read_q) begin
				nack_d = rx_q[9];
				rdd_d = rx_q[8:1];
			end else if (hasd_q) begin
				nack_d = rx_q[18] | rx_q[9] | rx_q[0];
			end else begin
				nack_d = rx_q[9] | rx_q[0];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			st_q <= PLO_H_IDLE;
			div_q <= 8'h00;
			qc_q <= 2'h0;
			bit_q <= 5'h00;
			last_q <= PLO_LAST_SHORT;
			tx_q <= 27'h7FFFFFF;
			rx_q <= 27'h0;
			hold_q <= 1'b0;
			read_q <= 1'b0;
			hasd_q <= 1'b0;
			scl_q <= 1'b1;
			oe_q <= 1'b0;
			ready_q <= 1'b0;
			done_q <= 1'b0;
			nack_q <= 1'b0;
			rdd_q <= 8'h00;
			sda_sync_q <= 2'h3;
		end else begin
			st_q <= st_d;
			div_q <= div_d;
			qc_q <= qc_d;
			bit_q <= bit_d;
			last_q <= last_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			hold_q <= hold_d;
			read_q <= read_d;
			hasd_q <= hasd_d;
			scl_q <= scl_d;
			oe_q <= oe_d;
			ready_q <= (st_q == PLO_H_IDLE && !ready_q && !cmd_valid)
				? 1'b1 : ready_d;
			done_q <= done_d;
			nack_q <= nack_d;
			rdd_q <= rdd_d;
			sda_sync_q <= {sda_sync_q[0], link.sda};
		end
	end

	assign link.scl = scl_q;
	assign link.host_sda_oe = oe_q;
	assign cmd_ready = ready_q;
	assign done = done_q;
	assign nack_seen = nack_q;
	assign rd_data = rdd_q;

endmodule : plo_host

// *** plo_link_sva.sv ***
// Checker for the two-wire link and the potentiometer device outputs.
`timescale 1ns/1ps
module plo_link_sva
	import plo_pkg::*;
#(
	parameter int CHANNELS = 2
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic scl,
	input wire logic dev_sda_oe,
	input wire logic power_down_pin_n,
	input wire logic logic_out_a,
	input wire logic logic_out_b,
	input wire logic [CHANNELS-1:0] term_a_open,
	input wire logic [CHANNELS-1:0][7:0] wiper_position_register
);
	// ****************************************
	// Bus idle counter
	// ****************************************
	// Counts clock cycles with the link clock high, saturating at 31.
	logic [4:0] idle_q;
	logic [4:0] idle_d;

	always_comb begin
		idle_d = idle_q;
		if (!scl)
			idle_d = 5'h00;
		else if (idle_q != 5'h1F)
			idle_d = idle_q + 5'h01;
	end

	always_ff @(posedge mclk) begin
		if (!resetn)
			idle_q <= 5'h00;
		else
			idle_q <= idle_d;
	end

	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	property p_out_rst;
		$rose(resetn) |-> (!logic_out_a && !logic_out_b) [*8];
	endproperty
	a_out_rst: assert property (p_out_rst) else $error("outputs high after reset");

	property p_pin_power_down_pin_n;
		!power_down_pin_n [*5] |-> term_a_open == {CHANNELS{1'b1}};
	endproperty
	a_pin_power_down_pin_n: assert property (p_pin_power_down_pin_n) else $error("pin did not shut down");

	property p_wipe0;
		term_a_open[0] |-> wiper_position_register[0] == 8'h00;
	endproperty
	a_wipe0: assert property (p_wipe0) else $error("wiper 0 not at B");

	property p_wipe1;
		term_a_open[CHANNELS-1] |-> wiper_position_register[CHANNELS-1] == 8'h00;
	endproperty
	a_wipe1: assert property (p_wipe1) else $error("wiper 1 not at B");

	property p_term_rel;
		$fell(term_a_open[0]) |-> $past(power_down_pin_n, 2);
	endproperty
	a_term_rel: assert property (p_term_rel) else $error("left shutdown, pin low");

	property p_out_idle;
		idle_q >= 5'h10 |-> $stable({logic_out_a, logic_out_b});
	endproperty
	a_out_idle: assert property (p_out_idle) else $error("outputs moved on idle bus");

	property p_quiet_idle;
		idle_q >= 5'h10 |-> !dev_sda_oe;
	endproperty
	a_quiet_idle: assert property (p_quiet_idle) else $error("device drives idle bus");

	property p_ack_low;
		$changed(dev_sda_oe) |-> !scl;
	endproperty
	a_ack_low: assert property (p_ack_low) else $error("data moved, clock high");

	c_shut: cover property (term_a_open == {CHANNELS{1'b1}});
	c_outs: cover property (logic_out_a && logic_out_b);
	c_ack: cover property ($rose(dev_sda_oe));
endmodule : plo_link_sva

// *** pot_logic_out_shutdown_ctrl_test.sv ***
// Testbench joining bus master and potentiometer device over the link.
`timescale 1ns/1ps
module pot_logic_out_shutdown_ctrl_test;
	import plo_pkg::*;
	logic mclk;
	logic resetn;
	logic cmd_valid;
	logic cmd_ready;
	logic cmd_read;
	logic cmd_has_data;
	logic cmd_hold;
	logic [1:0] cmd_strap;
	logic [7:0] cmd_instr;
	logic [7:0] cmd_data;
	logic done;
	logic nack_seen;
	logic [7:0] rd_data;
	logic loop_q;
	logic pin_q;
	logic power_down_pin_n;
	logic logic_out_a;
	logic logic_out_b;
	logic [1:0] term_a_open;
	logic [1:0][7:0] wiper;
	int n_fail;
	int checks;

	plo_if link();
	// Output A may be looped back to the power-down pin.
	assign power_down_pin_n = loop_q ? logic_out_a : pin_q;

	plo_host plo_host_i (.link(link), .mclk(mclk), .resetn(resetn),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
		.cmd_has_data(cmd_has_data), .cmd_hold(cmd_hold),
		.cmd_strap(cmd_strap), .cmd_instr(cmd_instr), .cmd_data(cmd_data),
		.done(done), .nack_seen(nack_seen), .rd_data(rd_data));
	plo_dev #(.CHANNELS(2)) plo_dev_i (.link(link), .mclk(mclk),
		.resetn(resetn), .addr_strap_lo(1'b1), .addr_strap_hi(1'b0),
		.power_down_pin_n(power_down_pin_n), .logic_out_a(logic_out_a),
		.logic_out_b(logic_out_b), .term_a_open(term_a_open),
		.wiper_position_register(wiper));
	plo_link_sva #(.CHANNELS(2)) plo_link_sva_i (.mclk(mclk),
		.resetn(resetn), .scl(link.scl), .dev_sda_oe(link.dev_sda_oe),
		.power_down_pin_n(power_down_pin_n), .logic_out_a(logic_out_a),
		.logic_out_b(logic_out_b), .term_a_open(term_a_open),
		.wiper_position_register(wiper));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic wrap_up;
		if (n_fail == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic st(input logic [1:0] o, input logic [1:0] t,
		input logic [7:0] w0, input logic [7:0] w1);
		chk({6'h00, logic_out_b, logic_out_a}, {6'h00, o});
		chk({6'h00, term_a_open}, {6'h00, t});
		chk(wiper[0], w0);
		chk(wiper[1], w1);
	endtask : st

	// Sends one frame and waits for its end, then lets the device settle.
	// Host outputs are looked at on the falling clock, where they have
	// settled; the request is raised only once ready stands, so a single
	// rising edge takes it.
	task automatic run(input logic rd, input logic hd, input logic hold,
		input logic [1:0] strap, input logic [7:0] instr, input logic [7:0] data);
		int i;
		i = 0;
		@(negedge mclk);
		while (cmd_ready !== 1'b1 && i < 100) begin
			@(negedge mclk);
			i++;
		end
		if (cmd_ready !== 1'b1)
			n_fail++;
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_read <= rd;
		cmd_has_data <= hd;
		cmd_hold <= hold;
		cmd_strap <= strap;
		cmd_instr <= instr;
		cmd_data <= data;
		@(posedge mclk);
		cmd_valid <= 1'b0;
		i = 0;
		@(negedge mclk);
		while (done !== 1'b1 && i < 2000) begin
			@(negedge mclk);
			i++;
		end
		if (done !== 1'b1)
			n_fail++;
		repeat (8) @(posedge mclk);
	endtask : run

	// ****************************************
	// Stimulus
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	initial begin
		repeat (30000) @(posedge mclk);
		n_fail++;
		wrap_up;
	end

	initial begin
		resetn = 1'b0;
		cmd_valid = 1'b0;
		cmd_read = 1'b0;
		cmd_has_data = 1'b0;
		cmd_hold = 1'b0;
		cmd_strap = 2'h0;
		cmd_instr = 8'h00;
		cmd_data = 8'h00;
		loop_q = 1'b1;
		pin_q = 1'b1;
		n_fail = 0;
		checks = 0;
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		repeat (8) @(posedge mclk);
		st(2'h0, 2'h3, 8'h00, 8'h00);
		run(1'b0, 1'b1, 1'b0, 2'h1, 8'h08, 8'h35);
		st(2'h1, 2'h0, 8'h35, 8'h80);
		loop_q <= 1'b0;
		run(1'b0, 1'b0, 1'b0, 2'h1, 8'h17, 8'h00);
		st(2'h2, 2'h0, 8'h35, 8'h80);
		run(1'b0, 1'b1, 1'b1, 2'h1, 8'h80, 8'h5A);
		run(1'b0, 1'b0, 1'b0, 2'h1, 8'h18, 8'h00);
		st(2'h3, 2'h0, 8'h35, 8'h5A);
		chk({7'h00, nack_seen}, 8'h00);
		run(1'b0, 1'b0, 1'b0, 2'h2, 8'h00, 8'h00);
		chk({7'h00, nack_seen}, 8'h01);
		st(2'h3, 2'h0, 8'h35, 8'h5A);
		run(1'b0, 1'b1, 1'b0, 2'h1, 8'hA0, 8'h44);
		st(2'h0, 2'h2, 8'h35, 8'h00);
		run(1'b0, 1'b0, 1'b0, 2'h1, 8'h80, 8'h00);
		st(2'h0, 2'h0, 8'h35, 8'h44);
		run(1'b0, 1'b0, 1'b0, 2'h1, 8'h40, 8'h00);
		st(2'h0, 2'h0, 8'h80, 8'h44);
		pin_q <= 1'b0;
		repeat (8) @(posedge mclk);
		st(2'h0, 2'h3, 8'h00, 8'h00);
		run(1'b0, 1'b1, 1'b0, 2'h1, 8'h00, 8'h21);
		st(2'h0, 2'h3, 8'h00, 8'h00);
		pin_q <= 1'b1;
		repeat (8) @(posedge mclk);
		st(2'h0, 2'h0, 8'h21, 8'h44);
		run(1'b1, 1'b0, 1'b0, 2'h1, 8'h00, 8'h00);
		chk(rd_data, 8'h21);
		run(1'b0, 1'b0, 1'b0, 2'h1, 8'h18, 8'h00);
		resetn <= 1'b0;
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		repeat (8) @(posedge mclk);
		st(2'h0, 2'h0, 8'h80, 8'h80);
		wrap_up;
	end
endmodule : pot_logic_out_shutdown_ctrl_test
